/* rtl/ocr_gate.sv */
// Over-current shutdown, automatic recovery and PWM gating for eleven
// outputs (six half bridges, five high-side switches).
// Assumes over-current detect and PWM inputs come from pins (synchronised
// here) and on bits and global enable come from same-clock logic.
`timescale 1ns/100ps
module ocr_gate import ocr_pkg::*; #(
  parameter int REC_SLOW_CYCLES = REC_SLOW_CYC,
  parameter int REC_FAST_CYCLES = REC_FAST_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control word write port
  input wire logic ctl_wr_en,
  input wire logic ctl_wr_sel,
  input wire logic [15:0] ctl_wr_data,
  // Control word readback
  output logic [15:0] hb_ctl_rd,
  output logic [15:0] hs_ctl_rd,
  // Global enable and on bits, bit 11 is output one high side
  input wire logic global_enable,
  input wire logic [NUM_HB_DRV-1:0] hb_on,
  input wire logic [NUM_HS-1:0] hs_on,
  // Gating inputs from pins
  input wire logic gating_input_a,
  input wire logic gating_input_b,
  // Over-current detectors from the power stages
  input wire logic [NUM_HB_DRV-1:0] hb_oc_det,
  input wire logic [NUM_HS-1:0] hs_oc_det,
  // Flag clear pulses, one per flag
  input wire logic [NUM_HB_DRV-1:0] hb_flag_clr,
  input wire logic [NUM_HS-1:0] hs_flag_clr,
  // Over-current flags, status words one and two
  output logic [NUM_HB_DRV-1:0] hb_overcurrent_flag,
  output logic [NUM_HS-1:0] hs_overcurrent_flag,
  // Driver enables
  output logic [NUM_HB-1:0] high_side_driver_hb,
  output logic [NUM_HB-1:0] low_side_driver,
  output logic [NUM_HS-1:0] high_side_driver
);

  localparam int N = NUM_HB_DRV + NUM_HS;

  // ==========================================================
  // Synchronisers
  logic [N+1:0] sync1_r, sync2_r;
  always_ff @(posedge clk) begin
    sync1_r <= {gating_input_b, gating_input_a, hb_oc_det, hs_oc_det};
    sync2_r <= sync1_r;
  end
  logic pwm_a, pwm_b;
  logic [N-1:0] oc_s;
  assign pwm_a = sync2_r[N];
  assign pwm_b = sync2_r[N+1];
  assign oc_s = sync2_r[N-1:0];

  // ==========================================================
  // Control words
  logic [15:0] hb_word_r, hb_word_nxt, hs_word_r, hs_word_nxt;
  always_comb begin
    hb_word_nxt = hb_word_r;
    hs_word_nxt = hs_word_r;
    if (!global_enable) begin
      hb_word_nxt = HB_WORD_RESET;
      hs_word_nxt = HS_WORD_RESET;
    end else if (ctl_wr_en && ctl_wr_sel == SEL_HB_WORD) begin
      hb_word_nxt = ctl_wr_data & HB_WORD_MASK; // Reserved bits dropped
    end else if (ctl_wr_en && ctl_wr_sel == SEL_HS_WORD) begin
      hs_word_nxt = ctl_wr_data & HS_WORD_MASK;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      hb_word_r <= HB_WORD_RESET;
      hs_word_r <= HS_WORD_RESET;
    end else begin
      hb_word_r <= hb_word_nxt;
      hs_word_r <= hs_word_nxt;
    end
  end
  assign hb_ctl_rd = hb_word_r;
  assign hs_ctl_rd = hs_word_r;

  // Field extraction, top bit of each field is output one (half-bridge words) or output seven (high-side fields)
  logic [NUM_HB-1:0] hb_rec_en, hb_pwm_en;
  logic [NUM_HS-1:0] hs_rec_en, hs_pwm_en;
  logic fast_sel;
  assign hb_rec_en = hb_word_r[HB_OCR_MSB:HB_OCR_LSB];
  assign hb_pwm_en = hb_word_r[HB_PWM_MSB:HB_PWM_LSB];
  assign hs_rec_en = hs_word_r[HS_OCR_MSB:HS_OCR_LSB];
  assign hs_pwm_en = hs_word_r[HS_PWM_MSB:HS_PWM_LSB];
  assign fast_sel = hs_word_r[HS_FREQ_BIT];

  // Per-driver recovery enable, half-bridge drivers share their output bit
  logic [N-1:0] rec_en;
  always_comb begin
    for (int k = 0; k < NUM_HB; k++) begin
      rec_en[NUM_HS + 2*k + 1] = hb_rec_en[k];
      rec_en[NUM_HS + 2*k] = hb_rec_en[k];
    end
    rec_en[NUM_HS-1:0] = hs_rec_en;
  end

  // ==========================================================
  // Recovery period timer
  logic [CNT_W-1:0] cnt_r, cnt_nxt, period_m1;
  logic rec_tick, late_phase;
  assign period_m1 = fast_sel ? CNT_W'(REC_FAST_CYCLES - 1)
                              : CNT_W'(REC_SLOW_CYCLES - 1);
  assign rec_tick = (cnt_r >= period_m1);
  assign late_phase = (cnt_r > (period_m1 >> 1));
  always_comb begin
    cnt_nxt = rec_tick ? '0 : cnt_r + CNT_W'(1);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Trip latches, single-shot arms and sticky flags
  logic [N-1:0] trip_r, trip_nxt, shot_r, shot_nxt, flag_r, flag_nxt;
  logic [N-1:0] flag_clr, oc_new;
  assign flag_clr = {hb_flag_clr, hs_flag_clr};
  assign oc_new = oc_s & ~trip_r;
  always_comb begin
    trip_nxt = trip_r;
    shot_nxt = shot_r;
    for (int i = 0; i < N; i++) begin
      if (oc_new[i]) begin
        trip_nxt[i] = 1'b1;
        shot_nxt[i] = late_phase; // Late trip earns one retry
      end else if (trip_r[i] && rec_tick && (rec_en[i] || shot_r[i])) begin
        trip_nxt[i] = 1'b0;
        shot_nxt[i] = 1'b0;
      end
    end
    // Set wins over clear
    flag_nxt = (flag_r & ~flag_clr) | oc_s;
    if (!global_enable) begin
      trip_nxt = '0;
      shot_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      trip_r <= '0;
      shot_r <= '0;
      flag_r <= '0;
    end else begin
      trip_r <= trip_nxt;
      shot_r <= shot_nxt;
      flag_r <= flag_nxt;
    end
  end
  assign hb_overcurrent_flag = flag_r[N-1:NUM_HS];
  assign hs_overcurrent_flag = flag_r[NUM_HS-1:0];

  // ==========================================================
  // Driver outputs
  logic [NUM_HB-1:0] hb_hs_nxt, hb_ls_nxt, hb_hs_r, hb_ls_r;
  logic [NUM_HS-1:0] hs_nxt, hs_r;
  always_comb begin
    logic g, a, b;
    g = 1'b0;
    a = 1'b0;
    b = 1'b0;
    for (int k = 0; k < NUM_HB; k++) begin
      // Field order runs output one at the top
      g = !hb_pwm_en[k] || (HB_USE_B[NUM_HB-1-k] ? pwm_b : pwm_a);
      a = hb_on[2*k+1] && !trip_r[NUM_HS+2*k+1] && g;
      b = hb_on[2*k] && !trip_r[NUM_HS+2*k] && g;
      hb_hs_nxt[k] = a && !b;
      hb_ls_nxt[k] = b && !a;
    end
    for (int j = 0; j < NUM_HS; j++) begin
      g = !hs_pwm_en[j] || (HS_USE_B[NUM_HS-1-j] ? pwm_b : pwm_a);
      hs_nxt[j] = hs_on[j] && !trip_r[j] && g;
    end
    if (!global_enable) begin
      hb_hs_nxt = '0;
      hb_ls_nxt = '0;
      hs_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      hb_hs_r <= '0;
      hb_ls_r <= '0;
      hs_r <= '0;
    end else begin
      hb_hs_r <= hb_hs_nxt;
      hb_ls_r <= hb_ls_nxt;
      hs_r <= hs_nxt;
    end
  end
  // Vector bit k is field bit k: top bit is output one / output seven
  assign high_side_driver_hb = hb_hs_r;
  assign low_side_driver = hb_ls_r;
  assign high_side_driver = hs_r;

endmodule : ocr_gate

/* rtl/ocr_pkg.sv */
// Constants for the over-current recovery and output gating block.
// Assumes a 20 MHz core clock and on bits supplied by the control words
// of the surrounding device.
//
// Function
// - Over-current on a driver sets its sticky flag and switches it off.
// - With recovery enabled, a tripped driver is re-enabled after a delay.
// - One recovery cycle may happen with recovery disabled, by clock phase.
// - Half-bridge flags form status word one, high-side flags word two.
// - Gated output is on only while its PWM input is high.
// - Outputs five, eight and ten use input B; all others input A.
// - Bit 5 of word two picks recovery rate: 0 is 1.7 kHz, 1 is 3 kHz.
// - Without gating, a driver follows its on bit directly.
// - High-side and low-side of one half bridge never on together.
// - Global enable cleared clears recovery and gating selections.
package ocr_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_HB = 6;
  localparam int NUM_HS = 5;
  localparam int NUM_HB_DRV = 2 * NUM_HB;
  localparam int CNT_W = 16;

  // ==========================================================
  // Register selects and field positions
  localparam logic SEL_HB_WORD = 1'b0;
  localparam logic SEL_HS_WORD = 1'b1;
  localparam int HB_OCR_MSB = 15;
  localparam int HB_OCR_LSB = 10;
  localparam int HB_PWM_MSB = 7;
  localparam int HB_PWM_LSB = 2;
  localparam int HS_OCR_MSB = 15;
  localparam int HS_OCR_LSB = 11;
  localparam int HS_PWM_MSB = 10;
  localparam int HS_PWM_LSB = 6;
  localparam int HS_FREQ_BIT = 5;
  localparam logic [15:0] HB_WORD_RESET = 16'h0000;
  localparam logic [15:0] HS_WORD_RESET = 16'h0000;
  localparam logic [15:0] HB_WORD_MASK = 16'hfcfc;
  localparam logic [15:0] HS_WORD_MASK = 16'hffe0;

  // ==========================================================
  // Gating input assignment, one bit per output, set means input B
  localparam logic [NUM_HB-1:0] HB_USE_B = 6'h10; // Output five
  localparam logic [NUM_HS-1:0] HS_USE_B = 5'h0a; // Outputs eight, ten

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int REC_SLOW_HZ = 1700;
  localparam int REC_FAST_HZ = 3000;
  localparam int REC_SLOW_CYC = CLK_HZ / REC_SLOW_HZ;
  localparam int REC_FAST_CYC = CLK_HZ / REC_FAST_HZ;

endpackage : ocr_pkg

/* tb/ocr_mcu.sv */
// Controller model driving the two gating pins.
// Levels come from the bench; pins change just after a rising edge.
`timescale 1ns/100ps
module ocr_mcu (
  // Clock and requested levels, [0] is input A
  input wire logic clk,
  input wire logic [1:0] lvl,
  // Gating pins
  output logic gating_input_a = 1'b0,
  output logic gating_input_b = 1'b0
);
  // ==========
  // Pin drivers
  always @(posedge clk) begin
    gating_input_a <= lvl[0];
    gating_input_b <= lvl[1];
  end
endmodule // ocr_mcu

/* tb/ocr_monitor.sv */
// Port checker for the over-current and gating block.
// Assumes it is bound to ocr_gate and shares its clock.
`timescale 1ns/100ps
module ocr_monitor import ocr_pkg::*; (
  // Observed ports
  input wire logic clk, rst, ctl_wr_en, ctl_wr_sel, global_enable,
  input wire logic gating_input_a, gating_input_b,
  input wire logic [15:0] ctl_wr_data, hb_ctl_rd, hs_ctl_rd,
  input wire logic [11:0] hb_on, hb_overcurrent_flag,
  input wire logic [4:0] hs_on, hs_oc_det, hs_overcurrent_flag,
  input wire logic [5:0] high_side_driver_hb, low_side_driver,
  input wire logic [4:0] high_side_driver
);
  // ==========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_hb_word_wr: assert property (
    ctl_wr_en && global_enable && !ctl_wr_sel |=>
    hb_ctl_rd == ($past(ctl_wr_data) & HB_WORD_MASK)) else $error("hb word");
  a_hs_word_wr: assert property (
    ctl_wr_en && global_enable && ctl_wr_sel |=>
    hs_ctl_rd == ($past(ctl_wr_data) & HS_WORD_MASK)) else $error("hs word");
  a_standby_clear: assert property (
    !global_enable |=> hb_ctl_rd == 16'h0000 && hs_ctl_rd == 16'h0000)
    else $error("standby");
  a_no_overlap: assert property (
    (high_side_driver_hb & low_side_driver) == 6'h00) else $error("overlap");
  a_flag_set: assert property (
    $rose(hs_oc_det[2]) |-> ##[1:4] hs_overcurrent_flag[2])
    else $error("flag");
  a_follow_on: assert property (
    (global_enable && !hs_ctl_rd[10] && !hs_overcurrent_flag[4] &&
    $stable(hs_on[4]))[*3] |-> high_side_driver[4] == hs_on[4])
    else $error("follow");
  a_gate_a_half_bridge_output_1: assert property (
    (global_enable && hb_on[11] && !hb_on[10] && hb_ctl_rd[7] &&
    !hb_overcurrent_flag[11] && $stable(gating_input_a))[*4]
    |-> high_side_driver_hb[5] == gating_input_a) else $error("gate a");
  a_gate_b_high_side_output_8: assert property (
    (global_enable && hs_on[3] && hs_ctl_rd[9] &&
    !hs_overcurrent_flag[3] && $stable(gating_input_b))[*4]
    |-> high_side_driver[3] == gating_input_b) else $error("gate b");
  c_write: cover property (ctl_wr_en && global_enable);
  c_trip: cover property ($rose(hs_overcurrent_flag[2]));
  c_gated: cover property (hb_ctl_rd[7] && high_side_driver_hb[5]);
endmodule // ocr_monitor
bind ocr_gate ocr_monitor u_mon (.*);

/* tb/tb_ocr_gate.sv */
// Self-checking bench for ocr_gate with the controller model.
// Assumes recovery periods shortened to 40 and 20 cycles.
`timescale 1ns/100ps
module tb_ocr_gate import ocr_pkg::*; ;
  logic clk = 0, rst = 1, ctl_wr_en = 0, ctl_wr_sel = 0, global_enable = 1;
  logic [15:0] ctl_wr_data = '0, hb_ctl_rd, hs_ctl_rd;
  logic [11:0] hb_on = '0, hb_oc_det = '0, hb_flag_clr = '0;
  logic [11:0] hb_overcurrent_flag;
  logic [4:0] hs_on = '0, hs_oc_det = '0, hs_flag_clr = '0;
  logic [4:0] hs_overcurrent_flag, high_side_driver;
  logic [5:0] high_side_driver_hb, low_side_driver;
  logic gating_input_a, gating_input_b;
  logic [1:0] lvl = '0;
  int error_cnt = 0, n_tests = 0;
  ocr_gate #(.REC_SLOW_CYCLES(40), .REC_FAST_CYCLES(20)) dut (.*);
  ocr_mcu u_mcu (.*);
  // ==========
  // Clock and helpers
  initial forever #25 clk = ~clk;
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(logic sel, logic [15:0] d);
    ctl_wr_sel = sel;
    ctl_wr_data = d;
    ctl_wr_en = 1;
    cyc(1);
    ctl_wr_en = 0;
    cyc(1);
  endtask
  task automatic till(logic v, output int n);
    n = 0;
    while (high_side_driver[2] !== v && n < 100) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    chk("hb rst", 16'h0000, hb_ctl_rd);
    chk("hs rst", 16'h0000, hs_ctl_rd);
    wr(SEL_HB_WORD, 16'hfcfc);
    wr(SEL_HS_WORD, 16'hffff);
    chk("hb mask", 16'hfcfc, hb_ctl_rd);
    chk("hs mask", 16'hffe0, hs_ctl_rd);
    global_enable = 0;
    wr(SEL_HB_WORD, 16'hfcfc);
    global_enable = 1;
    chk("hb clr", 16'h0000, hb_ctl_rd);
    chk("hs clr", 16'h0000, hs_ctl_rd);
  endtask
  task automatic t_drive();
    hb_on = 12'hc00;
    hs_on = 5'h10;
    cyc(2);
    chk("both", 16'h0000, {high_side_driver_hb, low_side_driver});
    chk("follow", 16'h0010, high_side_driver);
  endtask
  task automatic t_gate();
    wr(SEL_HB_WORD, 16'h0088);
    wr(SEL_HS_WORD, 16'h0200);
    hb_on = 12'h808;
    hs_on = 5'h08;
    for (int i = 0; i < 4; i++) begin
      lvl = i[1:0];
      cyc(5);
      chk("gate hb", {10'h0, i[0], 3'h0, i[1], 1'h0}, high_side_driver_hb);
      chk("gate hs", {11'h0, i[1], 3'h0}, high_side_driver);
    end
  endtask
  task automatic t_oc(logic fast);
    int a, b;
    wr(SEL_HS_WORD, {2'h0, 1'h1, 7'h0, fast, 5'h0});
    wr(SEL_HB_WORD, 16'h0000);
    hs_on = 5'h04;
    hb_on = 12'h001;
    cyc(2);
    chk("on", 16'h0004, high_side_driver);
    hs_oc_det = 5'h04;
    hb_oc_det = 12'h001;
    cyc(6);
    chk("hs flag", 16'h0004, hs_overcurrent_flag);
    chk("hb flag", 16'h0001, hb_overcurrent_flag);
    till(1, a);
    till(0, a);
    till(1, b);
    // A late trip may earn one retry; a period later the driver stays off
    chk("hb off", 16'h0000, low_side_driver);
    chk("period", fast ? 16'h0014 : 16'h0028, 16'(a + b));
    hs_oc_det = '0;
    hb_oc_det = '0;
    cyc(4);
    hs_flag_clr = 5'h04;
    hb_flag_clr = 12'h001;
    cyc(1);
    hs_flag_clr = '0;
    hb_flag_clr = '0;
    cyc(2);
    chk("flags", 16'h0000, {hs_overcurrent_flag, hb_overcurrent_flag});
    global_enable = 0;
    cyc(1);
    global_enable = 1;
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    cyc(8);
    rst = 0;
    t_regs();
    t_drive();
    t_gate();
    t_oc(1'h0);
    t_oc(1'h1);
    summarize();
  end
  initial begin
    cyc(3000);
    error_cnt++;
    summarize();
  end
endmodule // tb_ocr_gate
